// >>> rtl/event_counter_pkg.sv
// constants shared by the event counter bank and its channels
// assumes a 40 MHz system clock and a 32-bit apb register bus
package event_counter_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          COUNT_W       = 32;
    localparam logic [31:0] COUNT_MAX     = 32'h7fff_ffff;
    localparam logic [31:0] COUNT_MIN     = 32'h8000_0001;
    localparam logic [31:0] COUNT_ZERO    = 32'h0000_0000;
    localparam logic [31:0] COUNT_ONE     = 32'h0000_0001;

    // apb map, byte addresses
    localparam int          ADDR_W        = 12;
    localparam logic [3:0]  PAGE_GLOBAL   = 4'h0;
    localparam logic [3:0]  PAGE_CHANNEL  = 4'h1;
    localparam logic [7:0]  OFS_ENABLE    = 8'h00;
    localparam logic [7:0]  OFS_INT_STAT  = 8'h04;
    localparam logic [7:0]  OFS_INT_MASK  = 8'h08;
    // per channel: 0x100 + channel * 0x20 + word * 4
    localparam logic [2:0]  CH_PRESET     = 3'h0;
    localparam logic [2:0]  CH_COMPARE    = 3'h1;
    localparam logic [2:0]  CH_COUNT      = 3'h2;
    localparam logic [2:0]  CH_FROZEN     = 3'h3;
    localparam logic [2:0]  CH_FROZEN_TS  = 3'h4;
    localparam logic [2:0]  CH_FLAGS      = 3'h5;
    localparam logic [2:0]  CH_NV_COUNT   = 3'h6;
    localparam logic [2:0]  CH_NV_FROZEN  = 3'h7;

    // interrupt status: bits 7:0 freeze captured, bits 15:8 count wrapped
    localparam int          IRQ_W         = 16;
    localparam int          IRQ_WRAP_LSB  = 8;

    localparam logic [7:0]  ENABLE_RESET  = 8'h00;
    localparam logic [15:0] MASK_RESET    = 16'h0000;
    localparam logic [31:0] PRESET_RESET  = 32'h0000_0000;
    localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
endpackage

// >>> rtl/count_channel.sv
// one signed up/down transition counter with preset, compare and freeze
// operands are same-clock logic; pass_tick marks one evaluation pass
`timescale 1ns/100ps
module count_channel (
    input  wire logic        clock,          // system clock
    input  wire logic        sys_rst,        // synchronous reset, high
    input  wire logic        pass_tick,      // evaluation pass strobe
    input  wire logic        enable,         // counter enabled
    input  wire logic        up_op,          // count up operand
    input  wire logic        down_op,        // count down operand
    input  wire logic        block_op,       // block counting operand
    input  wire logic        load_sel,       // load_preset_select operand
    input  wire logic        reset_op,       // reset operand
    input  wire logic        freeze_reset_op, // freeze and reset operand
    input  wire logic        freeze_count_op, // freeze and count operand
    input  wire logic [31:0] preset,         // preset value
    input  wire logic [31:0] compare,        // compare value
    input  wire logic [31:0] time_stamp,     // present date and time
    input  wire logic        save_req,       // power-down save pulse
    output logic      [31:0] count,          // accumulated count
    output logic      [31:0] frozen,         // frozen count
    output logic      [31:0] frozen_ts,      // frozen timestamp
    output logic      [31:0] nv_count,       // saved accumulated count
    output logic      [31:0] nv_frozen,      // saved frozen count
    output logic             above,          // count above compare
    output logic             equal,          // count equal compare
    output logic             below,          // count below compare
    output logic             freeze_evt,     // freeze happened, pulse
    output logic             wrap_evt        // count rolled over, pulse
);
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] frozen;
        logic [31:0] frozen_ts;
        logic [31:0] nv_count;
        logic [31:0] nv_frozen;
        logic        was_enabled;
        logic [5:0]  prev;
        logic        freeze_evt;
        logic        wrap_evt;
    } chan_state_t;

    chan_state_t st;
    chan_state_t next_st;
    logic [5:0]  now_ops;
    logic [5:0]  rise;
    logic [31:0] start_val;

    // previous-pass values: up, down, load, reset, freeze-reset, freeze-count
    assign now_ops   = {freeze_count_op, freeze_reset_op, reset_op, load_sel, down_op, up_op};
    assign rise      = now_ops & ~st.prev;
    assign start_val = load_sel ? preset : event_counter_pkg::COUNT_ZERO;

    always_comb begin
        next_st            = st;
        next_st.freeze_evt = 1'b0;
        next_st.wrap_evt   = 1'b0;
        if (pass_tick) begin
            next_st.prev        = now_ops;
            next_st.was_enabled = enable;
            if (enable && !st.was_enabled) begin
                next_st.count = start_val;
            end else if (enable) begin
                if (rise[4] || rise[5]) begin
                    next_st.frozen     = st.count;
                    next_st.frozen_ts  = time_stamp;
                    next_st.freeze_evt = 1'b1;
                end
                if (rise[3] || rise[4]) begin
                    next_st.count = start_val;
                end else if (rise[2]) begin
                    next_st.count = preset;
                end else if (!block_op && (rise[0] != rise[1])) begin
                    if (rise[0]) begin
                        if (st.count == event_counter_pkg::COUNT_MAX) begin
                            next_st.count    = event_counter_pkg::COUNT_MIN;
                            next_st.wrap_evt = 1'b1;
                        end else begin
                            next_st.count = st.count + event_counter_pkg::COUNT_ONE;
                        end
                    end else begin
                        if (st.count == event_counter_pkg::COUNT_MIN) begin
                            next_st.count    = event_counter_pkg::COUNT_MAX;
                            next_st.wrap_evt = 1'b1;
                        end else begin
                            next_st.count = st.count - event_counter_pkg::COUNT_ONE;
                        end
                    end
                end
            end
        end
        if (save_req) begin
            next_st.nv_count  = st.count;
            next_st.nv_frozen = st.frozen;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count      = st.count;
    assign frozen     = st.frozen;
    assign frozen_ts  = st.frozen_ts;
    assign nv_count   = st.nv_count;
    assign nv_frozen  = st.nv_frozen;
    assign freeze_evt = st.freeze_evt;
    assign wrap_evt   = st.wrap_evt;
    // signed two's-complement compare, flags exclusive by construction
    assign above      = $signed(st.count) > $signed(compare);
    assign equal      = st.count == compare;
    assign below      = $signed(st.count) < $signed(compare);
endmodule

// >>> rtl/event_counter_bank.sv
// bank of eight signed event counters behind an apb slave
// operands, pass strobe and timestamp come from same-clock logic;
// power_fail is an asynchronous pin
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module event_counter_bank (
    input  wire logic        clock,              // 40 MHz system clock
    input  wire logic        sys_rst,            // synchronous reset, high
    input  wire logic        psel,               // apb select
    input  wire logic        penable,            // apb enable
    input  wire logic        pwrite,             // apb write
    input  wire logic [11:0] paddr,              // apb byte address
    input  wire logic [31:0] pwdata,             // apb write data
    output logic      [31:0] prdata,             // apb read data
    output logic             pready,             // apb ready
    output logic             pslverr,            // apb error
    input  wire logic        pass_tick,          // evaluation pass strobe
    input  wire logic [31:0] time_stamp,         // present date and time
    input  wire logic [7:0]  up_op,              // per-channel up operand
    input  wire logic [7:0]  down_op,            // per-channel down operand
    input  wire logic [7:0]  block_op,           // per-channel block operand
    input  wire logic [7:0]  load_preset_select, // per-channel load operand
    input  wire logic [7:0]  reset_op,           // per-channel reset operand
    input  wire logic [7:0]  freeze_reset_op,    // per-channel freeze/reset
    input  wire logic [7:0]  freeze_count_op,    // per-channel freeze/count
    input  wire logic        power_fail,         // control power lost, pin
    output logic [7:0]       count_above_flag,   // count above compare
    output logic [7:0]       count_equal_flag,   // count equal compare
    output logic [7:0]       count_below_flag,   // count below compare
    output logic             nv_save_done,       // values saved, pulse
    output logic             irq                 // interrupt, level high
);
    localparam int NCH = event_counter_pkg::CHANNELS;

    typedef struct packed {
        logic [7:0]           enable;
        logic [15:0]          status;
        logic [15:0]          mask;
        logic [NCH-1:0][31:0] preset;
        logic [NCH-1:0][31:0] compare;
        logic [31:0]          rdata;
        logic                 rerr;
        logic [2:0]           pf_sync;
        logic                 pf_level;
        logic                 save;
    } bank_state_t;

    bank_state_t st;
    bank_state_t next_st;

    logic [NCH-1:0][31:0] count_w;
    logic [NCH-1:0][31:0] frozen_w;
    logic [NCH-1:0][31:0] frozen_ts_w;
    logic [NCH-1:0][31:0] nv_count_w;
    logic [NCH-1:0][31:0] nv_frozen_w;
    logic [NCH-1:0]       freeze_evt_w;
    logic [NCH-1:0]       wrap_evt_w;

    logic                 setup;
    logic                 access;
    logic [3:0]           page;
    logic [2:0]           ch_sel;
    logic [2:0]           ch_word;
    logic                 mapped;
    logic [31:0]          read_val;
    logic [15:0]          events;

    // one identical channel per counter
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            count_channel u_chan (
                .clock           (clock),
                .sys_rst         (sys_rst),
                .pass_tick       (pass_tick),
                .enable          (st.enable[g]),
                .up_op           (up_op[g]),
                .down_op         (down_op[g]),
                .block_op        (block_op[g]),
                .load_sel        (load_preset_select[g]),
                .reset_op        (reset_op[g]),
                .freeze_reset_op (freeze_reset_op[g]),
                .freeze_count_op (freeze_count_op[g]),
                .preset          (st.preset[g]),
                .compare         (st.compare[g]),
                .time_stamp      (time_stamp),
                .save_req        (st.save),
                .count           (count_w[g]),
                .frozen          (frozen_w[g]),
                .frozen_ts       (frozen_ts_w[g]),
                .nv_count        (nv_count_w[g]),
                .nv_frozen       (nv_frozen_w[g]),
                .above           (count_above_flag[g]),
                .equal           (count_equal_flag[g]),
                .below           (count_below_flag[g]),
                .freeze_evt      (freeze_evt_w[g]),
                .wrap_evt        (wrap_evt_w[g])
            );
        end
    endgenerate

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign page    = paddr[11:8];
    assign ch_sel  = paddr[7:5];
    assign ch_word = paddr[4:2];
    assign events  = {wrap_evt_w, freeze_evt_w};

    // address decode and read mux
    always_comb begin
        mapped   = 1'b0;
        read_val = 32'h0000_0000;
        if (paddr[1:0] == 2'b00) begin
            if (page == event_counter_pkg::PAGE_GLOBAL) begin
                unique case (paddr[7:0])
                    event_counter_pkg::OFS_ENABLE: begin
                        mapped   = 1'b1;
                        read_val = {24'h00_0000, st.enable};
                    end
                    event_counter_pkg::OFS_INT_STAT: begin
                        mapped   = 1'b1;
                        read_val = {16'h0000, st.status};
                    end
                    event_counter_pkg::OFS_INT_MASK: begin
                        mapped   = 1'b1;
                        read_val = {16'h0000, st.mask};
                    end
                    default: begin
                        mapped   = 1'b0;
                    end
                endcase
            end else if (page == event_counter_pkg::PAGE_CHANNEL) begin
                mapped = 1'b1;
                // live values readable at any time
                unique case (ch_word)
                    event_counter_pkg::CH_PRESET:    read_val = st.preset[ch_sel];
                    event_counter_pkg::CH_COMPARE:   read_val = st.compare[ch_sel];
                    event_counter_pkg::CH_COUNT:     read_val = count_w[ch_sel];
                    event_counter_pkg::CH_FROZEN:    read_val = frozen_w[ch_sel];
                    event_counter_pkg::CH_FROZEN_TS: read_val = frozen_ts_w[ch_sel];
                    event_counter_pkg::CH_FLAGS:     read_val = {29'h0000_0000,
                        count_above_flag[ch_sel], count_equal_flag[ch_sel],
                        count_below_flag[ch_sel]};
                    event_counter_pkg::CH_NV_COUNT:  read_val = nv_count_w[ch_sel];
                    event_counter_pkg::CH_NV_FROZEN: read_val = nv_frozen_w[ch_sel];
                endcase
            end
        end
    end

    always_comb begin
        next_st = st;
        // read data latched in setup so the access phase needs no wait
        if (setup) begin
            next_st.rdata = (!pwrite && mapped) ? read_val : 32'h0000_0000;
            next_st.rerr  = !mapped;
        end
        // status: hardware set wins over a write-one clear in the same cycle
        next_st.status = st.status | events;
        if (access && pwrite && mapped) begin
            if (page == event_counter_pkg::PAGE_GLOBAL) begin
                if (paddr[7:0] == event_counter_pkg::OFS_ENABLE) begin
                    next_st.enable = pwdata[7:0];
                end
                if (paddr[7:0] == event_counter_pkg::OFS_INT_STAT) begin
                    next_st.status = (st.status & ~pwdata[15:0]) | events;
                end
                if (paddr[7:0] == event_counter_pkg::OFS_INT_MASK) begin
                    next_st.mask = pwdata[15:0];
                end
            end else begin
                if (ch_word == event_counter_pkg::CH_PRESET) begin
                    next_st.preset[ch_sel] = pwdata;
                end
                if (ch_word == event_counter_pkg::CH_COMPARE) begin
                    next_st.compare[ch_sel] = pwdata;
                end
            end
        end
        // power-fail pin: three flops, level changes when last two agree
        next_st.pf_sync = {st.pf_sync[1:0], power_fail};
        if (st.pf_sync[1] == st.pf_sync[2]) begin
            next_st.pf_level = st.pf_sync[2];
        end
        next_st.save = next_st.pf_level && !st.pf_level;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st         <= '0;
            st.enable  <= event_counter_pkg::ENABLE_RESET;
            st.mask    <= event_counter_pkg::MASK_RESET;
            st.preset  <= {NCH{event_counter_pkg::PRESET_RESET}};
            st.compare <= {NCH{event_counter_pkg::COMPARE_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign prdata       = st.rdata;
    assign pready       = 1'b1;
    assign pslverr      = access && st.rerr;
    assign irq          = |(st.status & st.mask);
    // channels take the snapshot on the cycle after save
    assign nv_save_done = st.save;
endmodule

// >>> sim/logic_equations.sv
// partner model: the periodic logic pass that feeds the counter operands
// assumes the bank's clock and synchronous reset; operand levels come from the bench
`timescale 1ns/100ps
module logic_equations (
    input  wire logic        clock,      // system clock
    input  wire logic        sys_rst,    // synchronous reset, high
    output logic             pass_tick,  // one pass every four clocks
    output logic      [31:0] time_stamp  // free running time of day
);
    logic [1:0] div;

    // passes kept sparse so that operands always settle between them
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div        <= 2'h0;
            pass_tick  <= 1'b0;
            time_stamp <= 32'h0000_0000;
        end else begin
            div        <= div + 2'h1;
            pass_tick  <= (div == 2'h3);
            time_stamp <= time_stamp + 32'h0000_0001;
        end
    end
endmodule

// >>> sim/event_counter_bank_properties.sv
// checker: timing relations seen at the counter bank's ports
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module event_counter_bank_properties (
    input wire logic        clock,            // system clock
    input wire logic        sys_rst,          // synchronous reset
    input wire logic        psel,             // apb select
    input wire logic        penable,          // apb enable
    input wire logic        pwrite,           // apb write
    input wire logic [11:0] paddr,            // apb address
    input wire logic        pready,           // apb ready
    input wire logic        pslverr,          // apb error
    input wire logic        pass_tick,        // pass strobe
    input wire logic        power_fail,       // power loss pin
    input wire logic [7:0]  count_above_flag, // above flags
    input wire logic [7:0]  count_equal_flag, // equal flags
    input wire logic [7:0]  count_below_flag, // below flags
    input wire logic        nv_save_done,     // save pulse
    input wire logic        irq               // interrupt
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic quiet;
    assign quiet = !pass_tick && !(psel && penable && pwrite);

    property p_flags_onehot;
        ((count_above_flag & count_equal_flag) | (count_above_flag & count_below_flag)
         | (count_equal_flag & count_below_flag)) == 8'h00
        && (count_above_flag | count_equal_flag | count_below_flag) == 8'hff;
    endproperty
    a_flags_onehot: assert property (p_flags_onehot)
        else $error("compare flags not exclusive");
    property p_flags_hold;
        quiet |=> $stable({count_above_flag, count_equal_flag, count_below_flag});
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flags moved without a pass");
    property p_irq_hold;
        // status takes a channel event one clock after the pass that raised it
        quiet && !$past(pass_tick) |=> $stable(irq);
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq moved without a pass or write");
    property p_save_resp;
        $rose(power_fail) |-> ##[2:8] nv_save_done;
    endproperty
    a_save_resp: assert property (p_save_resp)
        else $error("no save after power loss");
    property p_save_cause;
        nv_save_done |-> $past(power_fail, 2);
    endproperty
    a_save_cause: assert property (p_save_cause)
        else $error("save without power loss");
    property p_save_pulse;
        nv_save_done |=> !nv_save_done;
    endproperty
    a_save_pulse: assert property (p_save_pulse)
        else $error("save pulse too long");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb access not ready");
    property p_misalign;
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_misalign: assert property (p_misalign)
        else $error("misaligned access not refused");
endmodule

bind event_counter_bank event_counter_bank_properties i_props (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .pass_tick(pass_tick),
    .power_fail(power_fail), .count_above_flag(count_above_flag),
    .count_equal_flag(count_equal_flag), .count_below_flag(count_below_flag),
    .nv_save_done(nv_save_done), .irq(irq));

// >>> sim/tb_event_counter_bank.sv
// testbench: drives the counter bank over apb and through operand edges
// assumes the pass model sets the pass rate and the time of day
`timescale 1ns/100ps
module tb_event_counter_bank;
    logic        clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        power_fail = 0, pready, pslverr, nv_save_done, irq, pass_tick, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, time_stamp, rdat, last_ts, ts_evt;
    logic [7:0]  up_op = 0, down_op = 0, block_op = 0, load_preset_select = 0;
    logic [7:0]  reset_op = 0, freeze_reset_op = 0, freeze_count_op = 0;
    logic [7:0]  count_above_flag, count_equal_flag, count_below_flag;
    int          n_mismatch = 0, n_checks = 0;

    always #12.5 clock = ~clock;

    logic_equations i_logic_equations (.clock(clock), .sys_rst(sys_rst),
        .pass_tick(pass_tick), .time_stamp(time_stamp));
    event_counter_bank i_event_counter_bank (.clock(clock), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pass_tick(pass_tick),
        .time_stamp(time_stamp), .up_op(up_op), .down_op(down_op), .block_op(block_op),
        .load_preset_select(load_preset_select), .reset_op(reset_op),
        .freeze_reset_op(freeze_reset_op), .freeze_count_op(freeze_count_op),
        .power_fail(power_fail), .count_above_flag(count_above_flag),
        .count_equal_flag(count_equal_flag), .count_below_flag(count_below_flag),
        .nv_save_done(nv_save_done), .irq(irq));

    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e, input string s);
        apb(0, a, 32'h0000_0000);
        chk(s, e, rdat);
    endtask

    // waits for pass edges; time sampled at the same edge as the operands
    task npass(input int n);
        repeat (n) begin
            @(posedge clock);
            while (pass_tick !== 1'b1) @(posedge clock);
            last_ts = time_stamp;
        end
    endtask

    // one rising then falling edge of an operand, each seen by a pass
    task op(input int k, input logic [7:0] m);
        case (k)
            0: up_op <= m;
            1: down_op <= m;
            2: freeze_reset_op <= m;
            3: freeze_count_op <= m;
            default: reset_op <= m;
        endcase
        npass(1);
        ts_evt = last_ts;
        up_op <= 0;
        down_op <= 0;
        freeze_reset_op <= 0;
        freeze_count_op <= 0;
        reset_op <= 0;
        npass(1);
    endtask

    function logic [11:0] ca(input int n, input int w);
        return 12'(32'h100 + n * 32 + w * 4);
    endfunction

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        finish_test;
    end

    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 0;
        @(posedge clock);
        rd(12'h000, 32'h0000_0000, "enable");
        rd(ca(0, 5), 32'h0000_0002, "flags reset");
        rd(12'h0f0, 32'h0000_0000, "unmapped");
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        rd(12'h002, 32'h0000_0000, "misaligned");
        chk("misaligned err", 32'h0000_0001, {31'h0, err});
        apb(1, ca(0, 2), 32'h0000_0009);
        rd(ca(0, 2), 32'h0000_0000, "read only");
        apb(1, ca(0, 0), 32'h0000_0005);
        apb(1, ca(0, 1), 32'h0000_0007);
        apb(1, ca(2, 0), event_counter_pkg::COUNT_MAX);
        apb(1, 12'h008, 32'h0000_ff00);
        load_preset_select <= 8'h01;
        apb(1, 12'h000, 32'h0000_00ff);
        npass(2);
        rd(ca(0, 2), 32'h0000_0005, "preset start");
        rd(ca(1, 2), 32'h0000_0000, "zero start");
        repeat (3) op(0, 8'hff);
        for (int n = 0; n < 8; n++) rd(ca(n, 2), n == 0 ? 8 : 3, "count up");
        rd(ca(0, 5), 32'h0000_0004, "flags above");
        block_op <= 8'h01;
        op(0, 8'h01);
        block_op <= 8'h00;
        rd(ca(0, 2), 32'h0000_0008, "blocked");
        repeat (2) op(1, 8'h01);
        rd(ca(0, 2), 32'h0000_0006, "down");
        rd(ca(0, 5), 32'h0000_0001, "flags below");
        chk("above port", 32'h0000_00fe, {24'h0, count_above_flag});
        chk("below port", 32'h0000_0001, {24'h0, count_below_flag});
        load_preset_select <= 8'h04;
        npass(2);
        rd(ca(0, 2), 32'h0000_0006, "load fall");
        rd(ca(2, 2), event_counter_pkg::COUNT_MAX, "load rise");
        op(0, 8'h04);
        rd(ca(2, 2), event_counter_pkg::COUNT_MIN, "wrap up");
        chk("irq set", 32'h0000_0001, {31'h0, irq});
        op(1, 8'h04);
        rd(ca(2, 2), event_counter_pkg::COUNT_MAX, "wrap down");
        apb(1, 12'h004, 32'h0000_ffff);
        chk("irq clear", 32'h0000_0000, {31'h0, irq});
        up_op <= 8'h01;
        op(3, 8'h01);
        rd(ca(0, 3), 32'h0000_0006, "frozen");
        rd(ca(0, 4), ts_evt, "frozen time");
        rd(ca(0, 2), 32'h0000_0007, "count on");
        chk("equal", 32'h0000_0001, {31'h0, count_equal_flag[0]});
        op(2, 8'h01);
        rd(ca(0, 3), 32'h0000_0007, "frozen reset");
        rd(ca(0, 2), 32'h0000_0000, "reset zero");
        op(1, 8'h04);
        op(4, 8'h06);
        rd(ca(1, 2), 32'h0000_0000, "reset ch1");
        rd(ca(2, 2), event_counter_pkg::COUNT_MAX, "reset preset");
        power_fail <= 1;
        for (int i = 0; i < 20 && nv_save_done !== 1'b1; i++) @(posedge clock);
        chk("save pulse", 32'h0000_0001, {31'h0, nv_save_done});
        repeat (2) @(posedge clock);
        rd(ca(0, 7), 32'h0000_0007, "nv frozen");
        rd(ca(2, 6), event_counter_pkg::COUNT_MAX, "nv count");
        finish_test;
    end
endmodule
